// ===== cdr_clock_gen.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
module cdr_clock_gen (
	input  logic                         pclk,
	input  logic                         presetn,
	input  logic                         psel,
	input  logic                         penable,
	input  logic                         pwrite,
	input  logic [cdr_pkg::APB_AW-1:0]   paddr,
	input  logic [cdr_pkg::APB_DW-1:0]   pwdata,
	output logic [cdr_pkg::APB_DW-1:0]   prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  cdr_pkg::cdr_pins_s           pins,
	output logic                         cpu_clk_out,
	output logic                         periph_clk_out,
	output logic                         oscillator_out,
	output logic                         ready_out,
	output logic                         reset_out
);
	import cdr_pkg::*;

	// ***********************************************************
	// Declarations
	// ***********************************************************
	cdr_pins_s        spins;
	logic [PIN_W-1:0] spins_vec;

	logic [1:0]       ctrl;
	logic [1:0]       next_ctrl;
	logic [APB_DW-1:0] next_prdata;

	logic             src_level;
	logic             src_prev;
	logic             src_rise;
	logic [CNT_W-1:0] div_cnt;
	logic [CNT_W-1:0] next_div_cnt;
	logic             next_cpu_clk;
	logic             next_periph_clk;
	logic             cpu_rise;
	logic             cpu_fall;
	logic             hold;

	logic             ready_req;
	logic             first_sync_stage;
	logic             second_sync_stage;
	logic             next_first_sync_stage;
	logic             next_second_sync_stage;
	logic             next_reset_out;
	logic             sync_mode_select;
	logic             src_ext;

	// ***********************************************************
	// Pin synchronizers
	// ***********************************************************
	// Source clocks are oversampled, so their rate must stay well
	// below pclk for the divider to see every edge
	cdr_pin_sync #(
		.WIDTH    (PIN_W),
		.IDLE_VAL (PIN_IDLE)
	) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (pins),
		.pin_out (spins_vec)
	);

	assign spins = cdr_pins_s'(spins_vec);

	// ***********************************************************
	// APB slave
	// ***********************************************************
	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		is_mapped = (a == CTRL_OFS) || (a == STATUS_OFS);
	endfunction : is_mapped

	// Zero wait states; read data is latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);

	always_comb
	begin
		next_ctrl   = ctrl;
		next_prdata = prdata;
		if (psel && penable && pwrite && (paddr == CTRL_OFS))
			next_ctrl = pwdata[1:0];
		if (psel && !penable && !pwrite)
		begin
			next_prdata = '0;
			if (paddr == CTRL_OFS)
				next_prdata[1:0] = ctrl;
			else if (paddr == STATUS_OFS)
			begin
				next_prdata[STAT_CPU_CLK_BIT]            = cpu_clk_out;
				next_prdata[STAT_PERIPH_BIT]             = periph_clk_out;
				next_prdata[STAT_READY_BIT]              = ready_out;
				next_prdata[STAT_RESET_BIT]              = reset_out;
				next_prdata[STAT_COUNT_LSB +: CNT_W]     = div_cnt;
				next_prdata[STAT_HOLD_BIT]               = hold;
				next_prdata[STAT_FIRST_BIT]              = first_sync_stage;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl   <= CTRL_RESET;
			prdata <= '0;
		end
		else
		begin
			ctrl   <= next_ctrl;
			prdata <= next_prdata;
		end
	end

	assign src_ext          = ctrl[CTRL_SRC_EXT_BIT];
	assign sync_mode_select = ctrl[CTRL_SYNC_MODE_BIT];

	// ***********************************************************
	// Source selection and divider
	// ***********************************************************
	// Chosen source level and its rising edge
	assign src_level = src_ext ? spins.external_clock_in // [R3]
	                           : spins.crystal_in;
	assign src_rise  = src_level && !src_prev;
	assign hold      = spins.clock_phase_sync_in; // [R11] [R15]

	// Count 0 is the single high source period of each cycle
	always_comb
	begin
		next_div_cnt = div_cnt;
		if (hold)
			next_div_cnt = '0; // [R8]
		else if (src_rise) // [R9]
		begin
			if (div_cnt == CNT_W'(DIV_FACTOR - 1)) // [R1]
				next_div_cnt = '0;
			else
				next_div_cnt = div_cnt + CNT_W'(1);
		end
		next_cpu_clk = hold || (next_div_cnt == '0); // [R13] [R8]
	end

	assign cpu_rise = next_cpu_clk && !cpu_clk_out;
	assign cpu_fall = !next_cpu_clk && cpu_clk_out;

	// Peripheral clock flips on CPU clock falls; phase sync forces it high
	always_comb
	begin
		next_periph_clk = periph_clk_out;
		if (hold)
			next_periph_clk = 1'b1; // [R8]
		else if (cpu_fall)
			next_periph_clk = !periph_clk_out; // [R2] [R17]
	end

	// Reset gives a defined phase anyway; the sync pulse realigns it
	always_ff @(posedge pclk or negedge presetn) // [R10]
	begin
		if (!presetn)
		begin
			src_prev       <= 1'b0;
			div_cnt        <= '0;
			cpu_clk_out    <= 1'b1;
			periph_clk_out <= 1'b1;
			oscillator_out <= 1'b0;
		end
		else
		begin
			src_prev       <= src_level;
			div_cnt        <= next_div_cnt;
			cpu_clk_out    <= next_cpu_clk;
			periph_clk_out <= next_periph_clk;
			oscillator_out <= spins.crystal_in; // [R4]
		end
	end

	// ***********************************************************
	// Ready and reset synchronization
	// ***********************************************************
	// Each request counts only while its own enable is low
	assign ready_req = (!spins.ready_enable_a_n && spins.bus_ready_req_a) // [R12]
	                || (!spins.ready_enable_b_n && spins.bus_ready_req_b); // [R16]

	always_comb
	begin
		next_first_sync_stage  = first_sync_stage;
		next_second_sync_stage = second_sync_stage;
		next_reset_out         = reset_out;
		if (cpu_rise)
			next_first_sync_stage = ready_req; // [R5]
		if (cpu_fall)
		begin
			next_reset_out = !spins.reset_request_n; // [R14]
			if (sync_mode_select)
				next_second_sync_stage = ready_req; // [R7]
			else
				// Low request bypasses the first stage
				next_second_sync_stage = ready_req && first_sync_stage; // [R5] [R6]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_sync_stage  <= 1'b0;
			second_sync_stage <= 1'b0;
			reset_out         <= 1'b1;
		end
		else
		begin
			first_sync_stage  <= next_first_sync_stage;
			second_sync_stage <= next_second_sync_stage;
			reset_out         <= next_reset_out;
		end
	end

	assign ready_out = second_sync_stage;

endmodule : cdr_clock_gen

// ===== cdr_clock_gen_assertions.sv
module cdr_clock_gen_assertions
(
	input logic                       pclk,
	input logic                       presetn,
	input logic                       psel,
	input logic                       penable,
	input logic                       pwrite,
	input logic [cdr_pkg::APB_AW-1:0] paddr,
	input logic [cdr_pkg::APB_DW-1:0] pwdata,
	input cdr_pkg::cdr_pins_s         pins,
	input logic                       cpu_clk_out,
	input logic                       periph_clk_out,
	input logic                       oscillator_out,
	input logic                       ready_out,
	input logic                       reset_out
);
	import cdr_pkg::*;

	// **********
	// Mode shadow and request
	// **********
	logic mode;
	logic next_mode;
	logic req;

	// Shadow of the sync mode bit, as the block sees it
	always_comb
	begin
		next_mode = mode;
		if (psel && penable && pwrite && paddr == CTRL_OFS)
			next_mode = pwdata[CTRL_SYNC_MODE_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= CTRL_RESET[CTRL_SYNC_MODE_BIT];
		else
			mode <= next_mode;
	end

	assign req = (!pins.ready_enable_a_n && pins.bus_ready_req_a)
		|| (!pins.ready_enable_b_n && pins.bus_ready_req_b);

	// **********
	// Properties
	// **********
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence cpu_fall;
		$fell(cpu_clk_out);
	endsequence

	// Long windows cover the pin synchronizer latency
	osc_follow_a: assert property (
		(pins.crystal_in == $past(pins.crystal_in))[*7]
		|-> oscillator_out == pins.crystal_in) else $error("osc lag");
	clk_hold_a: assert property (pins.clock_phase_sync_in[*7]
		|-> cpu_clk_out && periph_clk_out) else $error("hold lost");
	periph_toggle_a: assert property (cpu_fall
		|-> ##[0:1] $changed(periph_clk_out)) else $error("no toggle");
	ready_edge_a: assert property ($changed(ready_out)
		|-> cpu_fall) else $error("ready moved off fall");
	reset_edge_a: assert property ($changed(reset_out)
		|-> cpu_fall) else $error("reset moved off fall");
	reset_level_a: assert property ((!pins.reset_request_n)[*8]
		##0 cpu_fall |-> reset_out) else $error("reset missing");
	ready_single_a: assert property ((mode && req)[*8]
		##0 cpu_fall |-> ready_out) else $error("ready missing");
	ready_drop_a: assert property ((!req)[*8]
		##0 cpu_fall |-> !ready_out) else $error("ready stuck");
endmodule : cdr_clock_gen_assertions

bind cdr_clock_gen cdr_clock_gen_assertions u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pins, .cpu_clk_out, .periph_clk_out,
	.oscillator_out, .ready_out, .reset_out);

// ===== cdr_far_model.sv
module cdr_far_model
(
	input  logic pclk,
	input  logic sync_req,
	output logic crystal,
	output logic ext_clk,
	output logic phase_sync
);
	timeunit 1ns;
	timeprecision 1ns;

	// **********
	// Source clocks and phase sync
	// **********
	logic [4:0] xc = '0;
	logic [4:0] ec = '0;
	logic       held = 1'b0;

	// Sync moves mid low phase, well ahead of the next external rise
	always @(posedge pclk)
	begin
		xc <= (xc == 5'd15) ? '0 : xc + 5'd1;
		ec <= (ec == 5'd23) ? '0 : ec + 5'd1;
		if (ec == 5'd5)
			held <= sync_req;
	end

	assign crystal    = xc < 5'd8;
	assign ext_clk    = ec >= 5'd12;
	assign phase_sync = held;
endmodule : cdr_far_model

// ===== cdr_pin_sync.sv
module cdr_pin_sync #(
	parameter int               WIDTH    = 8,
	parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
	input  logic             pclk,
	input  logic             presetn,
	input  logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_out;

	// ***********************************************************
	// Agreement filter
	// ***********************************************************
	// A bit moves only once stages two and three match
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
			next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_out[i];
	end

	// Stage one feeds stage two only, to keep metastability contained
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1  <= IDLE_VAL;
			stage2  <= IDLE_VAL;
			stage3  <= IDLE_VAL;
			pin_out <= IDLE_VAL;
		end
		else
		begin
			stage1  <= pin_in;
			stage2  <= stage1;
			stage3  <= stage2;
			pin_out <= next_out;
		end
	end

endmodule : cdr_pin_sync

// ===== cdr_pkg.sv
// Contract
// [R1] CPU clock is selected source divided by three
// [R2] Peripheral clock runs at half CPU clock
// [R3] Select high takes external clock, low crystal
// [R4] Oscillator output carries raw crystal signal; here the synchronized crystal level, registered on pclk
// [R5] Double mode: rise sampled, then falling stage
// [R6] Double mode: low request skips first stage
// [R7] Single mode: falling stage captures both edges
// [R8] Phase sync high holds clocks high, counter reset
// [R9] Sync release restarts on next source edge
// [R10] Divider phase undefined until sync pulse
// [R11] Far side drives phase sync source-synchronous
// [R12] Each request honoured only while enable low
// [R13] CPU clock high one source period, low two
// [R14] Reset output is inverted input, CPU-clock synchronized
// [R15] Far side holds phase sync low with crystal
// [R16] Qualified requests are combined by OR
// [R17] Peripheral clock toggles on CPU clock falls
package cdr_pkg;

	// ***********************************************************
	// Timing and bus constants
	// ***********************************************************
	localparam int        CLK_PERIOD_NS = 8;
	localparam int        DIV_FACTOR    = 3;
	localparam int        CNT_W         = 2;
	localparam int        APB_AW        = 12;
	localparam int        APB_DW        = 32;

	// ***********************************************************
	// Register map
	// ***********************************************************
	localparam logic [APB_AW-1:0] CTRL_OFS   = 12'h000;
	localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;

	// Control fields
	localparam int         CTRL_SRC_EXT_BIT   = 0;
	localparam int         CTRL_SYNC_MODE_BIT = 1;
	localparam logic [1:0] CTRL_RESET         = 2'h2;

	// Status fields
	localparam int STAT_CPU_CLK_BIT  = 0;
	localparam int STAT_PERIPH_BIT   = 1;
	localparam int STAT_READY_BIT    = 2;
	localparam int STAT_RESET_BIT    = 3;
	localparam int STAT_COUNT_LSB    = 4;
	localparam int STAT_HOLD_BIT     = 6;
	localparam int STAT_FIRST_BIT    = 7;

	// ***********************************************************
	// Pin carrier
	// ***********************************************************
	typedef struct packed {
		logic crystal_in;
		logic external_clock_in;
		logic clock_phase_sync_in;
		logic ready_enable_a_n;
		logic ready_enable_b_n;
		logic bus_ready_req_a;
		logic bus_ready_req_b;
		logic reset_request_n;
	} cdr_pins_s;

	localparam int        PIN_W     = 8;
	// Idle levels: enables off, reset request released
	localparam logic [7:0] PIN_IDLE = 8'h19;

endpackage : cdr_pkg

// ===== clock_divider_ready_sync_bench.sv
module clock_divider_ready_sync_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cdr_pkg::*;

	// **********
	// Stimulus and wiring
	// **********
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready, pslverr, xtal, ext, sync;
	logic        cpu_clk_out, periph_clk_out, oscillator_out;
	logic        ready_out, reset_out;
	logic        en_a_n = 1'b1, en_b_n = 1'b1, ra = 1'b0, rb = 1'b0;
	logic        rst_n = 1'b1, sync_req = 1'b0;
	cdr_pins_s   pins;
	int          errors = 0, samples_checked = 0;

	assign pins = {xtal, ext, sync, en_a_n, en_b_n, ra, rb, rst_n};

	always #4 pclk = ~pclk;

	cdr_far_model u_far (.pclk, .sync_req, .crystal(xtal), .ext_clk(ext),
		.phase_sync(sync));
	cdr_clock_gen u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .pins, .cpu_clk_out,
		.periph_clk_out, .oscillator_out, .ready_out, .reset_out);

	// **********
	// Shared tasks
	// **********
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Times one high phase and one period, in pclk cycles
	task automatic span(ref logic s, output logic [31:0] hi, per);
		time t0;
		@(posedge s);
		t0 = $time;
		@(negedge s);
		hi = 32'(($time - t0) / 8);
		@(posedge s);
		per = 32'(($time - t0) / 8);
	endtask : span

	// Lets the fall's updates land before looking
	task automatic fall();
		@(negedge cpu_clk_out);
		repeat (2) @(posedge pclk);
	endtask : fall

	task automatic req(input logic b, v);
		if (b)
			rb <= v;
		else
			ra <= v;
	endtask : req

	// **********
	// Scenarios
	// **********
	task automatic regs();
		logic [31:0] r;
		logic        er;
		apb(1'b0, CTRL_OFS, 32'h0, r, er);
		chk("ctrl reset", r, 32'(CTRL_RESET));
		apb(1'b1, STATUS_OFS, 32'hff, r, er);
		chk("status write", 32'(er), 32'h0);
		apb(1'b0, 12'h008, 32'h0, r, er);
		chk("unmapped", {r[30:0], er}, 32'h1);
	endtask : regs

	task automatic clocks(input logic sel, input logic [31:0] sp);
		logic [31:0] r, hi, per;
		logic        er;
		apb(1'b1, CTRL_OFS, {31'h0, sel}, r, er);
		repeat (2) @(posedge cpu_clk_out);
		span(cpu_clk_out, hi, per);
		chk("cpu high", hi, sp);
		chk("cpu period", per, 3 * sp);
		span(periph_clk_out, hi, per);
		chk("periph high", hi, 3 * sp);
		chk("periph period", per, 6 * sp);
		span(oscillator_out, hi, per);
		chk("osc period", per, 32'h10);
	endtask : clocks

	task automatic hold();
		logic [31:0] hi, per, r;
		logic        er;
		sync_req <= 1'b1;
		repeat (200) @(posedge pclk);
		chk("held", 32'({cpu_clk_out, periph_clk_out}), 32'h3);
		// Status while held: both clocks high, hold flag, count zero
		apb(1'b0, STATUS_OFS, 32'h0, r, er);
		chk("held status", r, (32'h1 << STAT_CPU_CLK_BIT)
			| (32'h1 << STAT_PERIPH_BIT) | (32'h1 << STAT_HOLD_BIT));
		sync_req <= 1'b0;
		span(cpu_clk_out, hi, per);
		chk("resync period", per, 32'd72);
	endtask : hold

	task automatic rdy(input logic single, b);
		logic [31:0] r;
		logic        er;
		apb(1'b1, CTRL_OFS, {30'h0, single, 1'b1}, r, er);
		en_a_n <= b;
		en_b_n <= !b;
		req(!b, 1'b1);
		fall();
		fall();
		chk("ready gated", 32'(ready_out), 32'h0);
		req(!b, 1'b0);
		@(posedge cpu_clk_out);
		repeat (2) @(posedge pclk);
		req(b, 1'b1);
		fall();
		chk("ready first", 32'(ready_out), 32'(single));
		fall();
		chk("ready second", 32'(ready_out), 32'h1);
		@(posedge cpu_clk_out);
		repeat (2) @(posedge pclk);
		req(b, 1'b0);
		fall();
		chk("ready drop", 32'(ready_out), 32'h0);
	endtask : rdy

	task automatic rst();
		rst_n <= 1'b0;
		fall();
		fall();
		chk("reset on", 32'(reset_out), 32'h1);
		rst_n <= 1'b1;
		fall();
		fall();
		chk("reset off", 32'(reset_out), 32'h0);
	endtask : rst

	task automatic results();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// Main sequence; phase sync used only with the external source
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		regs();
		clocks(1'b0, 32'd16);
		clocks(1'b1, 32'd24);
		hold();
		rdy(1'b1, 1'b0);
		rdy(1'b0, 1'b1);
		rst();
		results();
	end

	// Watchdog far beyond the few thousand cycles needed
	initial
	begin
		#400000;
		errors++;
		results();
	end
endmodule : clock_divider_ready_sync_bench
